// >>> wmr_pkg.sv
// Shared constants and types for the weather station register bank.
package wmr_pkg;

	// Clock and time base.
	localparam int CLK_PERIOD_NS = 25; // System clock period in ns.
	localparam int SECOND_NS = 1_000_000_000; // One second in ns.
	localparam int TICK_CYCLES_DEF = SECOND_NS / CLK_PERIOD_NS; // Cycles per one-second tick.

	// Heater and refresh intervals, in seconds.
	localparam int TMR_W = 12; // Width of the seconds timers.
	localparam logic [11:0] HOUR_S = 12'h0E10; // 3600 s of high humidity.
	localparam logic [11:0] WATCH_S = HOUR_S + 12'h0001; // Strictly longer than one hour.
	localparam logic [11:0] HEAT_S = 12'h0258; // Heater on for 600 s.
	localparam logic [11:0] COOL_S = 12'h0258; // Cool-down of 600 s.
	localparam logic [11:0] SLOW_S = 12'h04B0; // Slow refresh, 1200 s.
	localparam logic [11:0] FAST_S = 12'h0002; // Normal refresh, 2 s.

	// Humidity threshold, percent * 100 (95.00 %).
	localparam logic [15:0] HUM_LIMIT = 16'h251C;

	// Protocol constants.
	localparam logic [7:0] SLAVE_NUM = 8'h0E; // Slave number 14.
	localparam logic [7:0] FC_READ_INPUT = 8'h04; // Read input registers.
	localparam logic [7:0] FC_WRITE_COIL = 8'h05; // Write single coil.
	localparam logic [7:0] EXC_FLAG = 8'h80; // Set in the function of an exception answer.
	localparam logic [7:0] EXC_FUNC = 8'h01; // Illegal function.
	localparam logic [7:0] EXC_ADDR = 8'h02; // Illegal data address.
	localparam logic [7:0] EXC_VALUE = 8'h03; // Illegal data value.
	localparam int INPUT_REG_BASE = 30001; // Register number of data address zero.

	// Input register data addresses.
	localparam logic [15:0] REG_DEVICE_IDENTIFIER = 16'h0000;
	localparam logic [15:0] REG_WIND_DIRECTION = 16'h0001;
	localparam logic [15:0] REG_WIND_SPEED_MEAN = 16'h0002;
	localparam logic [15:0] REG_WIND_GUST_PEAK = 16'h0003;
	localparam logic [15:0] REG_PRIMARY_TEMPERATURE = 16'h0004;
	localparam logic [15:0] REG_RAIN_LAST_HOUR = 16'h0005;
	localparam logic [15:0] REG_RAIN_LAST_DAY = 16'h0006;
	localparam logic [15:0] REG_RAIN_SINCE_MIDNIGHT = 16'h0007;
	localparam logic [15:0] REG_RELATIVE_HUMIDITY = 16'h0008;
	localparam logic [15:0] REG_BAROMETRIC_PRESSURE = 16'h0009;
	localparam logic [15:0] REG_LUMINOSITY = 16'h000A;
	localparam logic [15:0] REG_SNOW_FALL = 16'h000B;
	localparam logic [15:0] REG_RAIN_RAW_COUNT = 16'h000C;
	localparam logic [15:0] REG_BACKUP_TEMPERATURE = 16'h000D;
	localparam logic [15:0] REG_STATION_STATUS = 16'h000E;

	// Coil address and values.
	localparam logic [15:0] COIL_HEATER_ENABLE = 16'h0000;
	localparam logic [15:0] COIL_VAL_ON = 16'hFF00;
	localparam logic [15:0] COIL_VAL_OFF = 16'h0000;
	localparam logic COIL_RESET = 1'b0;

	// Status register bit positions.
	localparam int ST_HEATER_BIT = 0;
	localparam int ST_SLOW_BIT = 1;
	localparam int ST_ENABLE_BIT = 2;

	// Heater sequence states.
	typedef enum logic [1:0] {
		S_WATCH,
		S_LATCH,
		S_HEAT,
		S_COOL
	} wmr_heat_type;

endpackage : wmr_pkg

// >>> wmr_timer_if.sv
`timescale 1ns/10ps
// Control and result of one seconds timer.
interface wmr_timer_if;
	logic clear; // Restart the count at zero.
	logic tick; // One-second tick.
	logic [11:0] limit; // Count at which the timer expires.
	logic [11:0] count; // Seconds counted so far.
	logic expired; // Count has reached the limit.

	modport ctl (output clear, output tick, output limit, input count, input expired);
	modport tmr (input clear, input tick, input limit, output count, output expired);
endinterface : wmr_timer_if

// >>> wmr_tick.sv
`timescale 1ns/10ps
// Free-running prescaler giving a one-cycle pulse every DIV clocks.
module wmr_tick #(
	parameter int DIV = 40
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Tick output.
	output logic tick_o
);
	// State of the prescaler.
	typedef struct packed {
		logic [31:0] cnt; // Cycles since the last tick.
		logic tick; // Tick pulse.
	} wmr_tick_type;

	wmr_tick_type st_r; // Registered state.
	wmr_tick_type st_nxt; // Next state.

	// The counter wraps at DIV-1 and fires the tick on the wrap.
	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (st_r.cnt >= 32'(DIV - 1)) begin
			st_nxt.cnt = 32'h0000_0000;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + 32'h0000_0001;
		end
	end

	// State register.
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick_o = st_r.tick;
endmodule : wmr_tick

// >>> wmr_sec_timer.sv
`timescale 1ns/10ps
// Seconds timer that counts ticks up to a limit and then holds.
module wmr_sec_timer (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Control and result.
	wmr_timer_if.tmr tmr
);
	// State of the timer.
	typedef struct packed {
		logic [11:0] count; // Seconds counted.
	} wmr_tmr_type;

	wmr_tmr_type st_r; // Registered state.
	wmr_tmr_type st_nxt; // Next state.

	// Clear wins over a tick; counting stops at the limit.
	always_comb begin
		st_nxt = st_r;
		if (tmr.clear) begin
			st_nxt.count = 12'h000;
		end else if (tmr.tick && (st_r.count < tmr.limit)) begin
			st_nxt.count = st_r.count + 12'h001;
		end
	end

	// State register.
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tmr.count = st_r.count;
	assign tmr.expired = (st_r.count >= tmr.limit);
endmodule : wmr_sec_timer

// >>> wmr_regs_heater.sv
`timescale 1ns/10ps
module wmr_regs_heater #(
	parameter int TICK_CYCLES = wmr_pkg::TICK_CYCLES_DEF, // Clocks per one-second tick.
	parameter logic [15:0] DEVICE_IDENTIFIER = 16'hD0C5 // Arbitrary identifier value.
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Decoded request from the frame layer.
	input wire logic req_valid_i,
	input wire logic [7:0] req_slave_i,
	input wire logic [7:0] req_func_i,
	input wire logic [15:0] req_addr_i,
	input wire logic [15:0] req_data_i,
	// Answer to the frame layer.
	output logic rsp_valid_o,
	output logic [7:0] rsp_func_o,
	output logic [15:0] rsp_data_o,
	output logic rsp_exc_o,
	// Measurements from the acquisition logic.
	input wire logic [15:0] wind_direction_i,
	input wire logic [15:0] wind_speed_mean_i,
	input wire logic [15:0] wind_gust_peak_i,
	input wire logic [15:0] temp_sample_i,
	input wire logic [15:0] rain_last_hour_i,
	input wire logic [15:0] rain_last_day_i,
	input wire logic [15:0] relative_humidity_i,
	input wire logic [15:0] barometric_pressure_i,
	input wire logic [15:0] luminosity_i,
	input wire logic [15:0] rain_raw_count_i,
	input wire logic [15:0] backup_temperature_i,
	// Heater drive and primary temperature view.
	output logic heater_on_o,
	output logic [15:0] primary_temperature_o
);
	import wmr_pkg::*;

	// Whole state of the block.
	typedef struct packed {
		wmr_heat_type heat; // Heater sequence state.
		logic heater_enable_coil; // Algorithm enable coil.
		logic heater; // Heater drive.
		logic [15:0] ptemp; // Primary temperature register.
		logic rsp_valid; // Answer pulse.
		logic [7:0] rsp_func; // Answer function code.
		logic [15:0] rsp_data; // Answer data or exception code.
		logic rsp_exc; // Answer is an exception.
	} wmr_main_type;

	wmr_main_type st_r; // Registered state.
	wmr_main_type st_nxt; // Next state.
	logic tick; // One-second tick.
	logic hum_high; // Humidity above the threshold.
	logic seq_active; // Heater sequence running.
	logic refresh_fire; // Slow or fast refresh is due.
	logic latch_now; // Temperature latched before heating.
	logic [15:0] status_word; // Status register contents.
	logic [15:0] rd_data; // Read mux output.
	logic rd_ok; // Read address is mapped.

	wmr_timer_if seq_tmr (); // Hour, heat and cool timer.
	wmr_timer_if ref_tmr (); // Temperature refresh timer.

	// One-second time base shared by both timers.
	wmr_tick #(
		.DIV(TICK_CYCLES)
	) u_tick (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.tick_o(tick)
	);

	// Sequence timer.
	wmr_sec_timer u_seq_tmr (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.tmr(seq_tmr.tmr)
	);

	// Refresh timer.
	wmr_sec_timer u_ref_tmr (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.tmr(ref_tmr.tmr)
	);

	// Status word and the read mux over the input registers.
	always_comb begin
		status_word = 16'h0000;
		status_word[ST_HEATER_BIT] = st_r.heater;
		status_word[ST_SLOW_BIT] = seq_active;
		status_word[ST_ENABLE_BIT] = st_r.heater_enable_coil;
		rd_ok = 1'b1;
		// Wire address is the register number minus the base.
		case (req_addr_i)
			REG_DEVICE_IDENTIFIER: rd_data = DEVICE_IDENTIFIER;
			REG_WIND_DIRECTION: rd_data = wind_direction_i;
			REG_WIND_SPEED_MEAN: rd_data = wind_speed_mean_i;
			REG_WIND_GUST_PEAK: rd_data = wind_gust_peak_i;
			REG_PRIMARY_TEMPERATURE: rd_data = st_r.ptemp;
			REG_RAIN_LAST_HOUR: rd_data = rain_last_hour_i;
			REG_RAIN_LAST_DAY: rd_data = rain_last_day_i;
			REG_RAIN_SINCE_MIDNIGHT: rd_data = 16'h0000; // Not implemented, reads zero.
			REG_RELATIVE_HUMIDITY: rd_data = relative_humidity_i;
			REG_BAROMETRIC_PRESSURE: rd_data = barometric_pressure_i;
			REG_LUMINOSITY: rd_data = luminosity_i;
			REG_SNOW_FALL: rd_data = 16'h0000; // Not implemented, reads zero.
			REG_RAIN_RAW_COUNT: rd_data = rain_raw_count_i;
			REG_BACKUP_TEMPERATURE: rd_data = backup_temperature_i;
			REG_STATION_STATUS: rd_data = status_word;
			default: begin
				rd_data = 16'h0000;
				rd_ok = 1'b0;
			end
		endcase
	end

	// Heater sequence, temperature refresh and request handling.
	always_comb begin
		st_nxt = st_r;
		st_nxt.rsp_valid = 1'b0;
		hum_high = (relative_humidity_i > HUM_LIMIT);
		seq_active = (st_r.heat != S_WATCH);
		latch_now = 1'b0;
		seq_tmr.tick = tick;
		ref_tmr.tick = tick;
		seq_tmr.clear = 1'b0;
		ref_tmr.clear = 1'b0;
		// Watch, heat and cool each time their own interval; latch takes the heat limit.
		case (st_r.heat)
			S_WATCH: seq_tmr.limit = WATCH_S;
			S_COOL: seq_tmr.limit = COOL_S;
			default: seq_tmr.limit = HEAT_S;
		endcase
		// Refresh every 20 minutes while a sequence runs, else every 2 s.
		ref_tmr.limit = seq_active ? SLOW_S : FAST_S;
		if (!st_r.heater_enable_coil) begin
			// Disabled: idle and hold the timer at zero.
			st_nxt.heat = S_WATCH;
			seq_tmr.clear = 1'b1;
		end else begin
			case (st_r.heat)
				S_WATCH: begin
					// Humid time must be unbroken; a dry moment restarts it.
					if (!hum_high) begin
						seq_tmr.clear = 1'b1;
					end else if (seq_tmr.expired) begin
						st_nxt.heat = S_LATCH;
						seq_tmr.clear = 1'b1;
					end
				end
				S_LATCH: begin
					// Store the ambient temperature before the sensor warms.
					latch_now = 1'b1;
					st_nxt.heat = S_HEAT;
					seq_tmr.clear = 1'b1;
				end
				S_HEAT: begin
					// Heater on for the full heating interval.
					if (seq_tmr.expired) begin
						st_nxt.heat = S_COOL;
						seq_tmr.clear = 1'b1;
					end
				end
				S_COOL: begin
					// After cool-down, heat again or go back to watching.
					if (seq_tmr.expired) begin
						st_nxt.heat = hum_high ? S_LATCH : S_WATCH;
						seq_tmr.clear = 1'b1;
					end
				end
				default: begin
					st_nxt.heat = S_WATCH;
					seq_tmr.clear = 1'b1;
				end
			endcase
		end
		st_nxt.heater = (st_nxt.heat == S_HEAT);
		// The latch also restarts the slow refresh interval.
		refresh_fire = ref_tmr.expired;
		if (latch_now || refresh_fire) begin
			st_nxt.ptemp = temp_sample_i;
			ref_tmr.clear = 1'b1;
		end
		// Requests to other slave numbers are ignored silently.
		if (req_valid_i && (req_slave_i == SLAVE_NUM)) begin
			st_nxt.rsp_valid = 1'b1;
			st_nxt.rsp_exc = 1'b0;
			st_nxt.rsp_func = req_func_i;
			st_nxt.rsp_data = req_data_i;
			case (req_func_i)
				FC_READ_INPUT: begin
					// Input registers are read only; unmapped addresses fault.
					if (rd_ok) begin
						st_nxt.rsp_data = rd_data;
					end else begin
						st_nxt.rsp_exc = 1'b1;
						st_nxt.rsp_data = {8'h00, EXC_ADDR};
					end
				end
				FC_WRITE_COIL: begin
					// Only coil 0 exists; the answer echoes the written value.
					if (req_addr_i != COIL_HEATER_ENABLE) begin
						st_nxt.rsp_exc = 1'b1;
						st_nxt.rsp_data = {8'h00, EXC_ADDR};
					end else if (req_data_i == COIL_VAL_ON) begin
						st_nxt.heater_enable_coil = 1'b1;
					end else if (req_data_i == COIL_VAL_OFF) begin
						st_nxt.heater_enable_coil = 1'b0;
					end else begin
						st_nxt.rsp_exc = 1'b1;
						st_nxt.rsp_data = {8'h00, EXC_VALUE};
					end
				end
				default: begin
					// Any other function is refused.
					st_nxt.rsp_exc = 1'b1;
					st_nxt.rsp_data = {8'h00, EXC_FUNC};
				end
			endcase
			if (st_nxt.rsp_exc) begin
				st_nxt.rsp_func = req_func_i | EXC_FLAG;
			end
		end
	end

	// State register; the coil powers up cleared.
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			st_r <= '0;
			st_r.heat <= S_WATCH;
			st_r.heater_enable_coil <= COIL_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs come straight from the state register.
	assign rsp_valid_o = st_r.rsp_valid;
	assign rsp_func_o = st_r.rsp_func;
	assign rsp_data_o = st_r.rsp_data;
	assign rsp_exc_o = st_r.rsp_exc;
	assign heater_on_o = st_r.heater;
	assign primary_temperature_o = st_r.ptemp;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);

	// The heater starts only after the latch cycle.
	chk_heat_after_latch: assert property (
		$rose(heater_on_o) |-> $past(st_r.heat) == S_LATCH)
		else $error("Heater started without a temperature latch.");

	// The heater stops only once the heating time has run out or on disable.
	chk_heat_length: assert property (
		$fell(heater_on_o) |-> ($past(seq_tmr.count) >= HEAT_S) || !$past(st_r.heater_enable_coil))
		else $error("Heater stopped before its heating time.");

	// Humid at the end of cool-down leads to a new latch.
	chk_relatch: assert property (
		(st_r.heater_enable_coil && st_r.heat == S_COOL && seq_tmr.expired && hum_high)
		|=> st_r.heat == S_LATCH)
		else $error("No relatch while still humid after cool-down.");

	// Dry at the end of cool-down re-arms the full hour.
	chk_rearm_hour: assert property (
		(st_r.heater_enable_coil && st_r.heat == S_COOL && seq_tmr.expired && !hum_high)
		|=> (st_r.heat == S_WATCH) && (seq_tmr.count == 12'h000))
		else $error("Hour not re-armed after a dry cool-down.");

	// The primary temperature changes only on a refresh or a latch.
	chk_refresh_cause: assert property (
		$changed(st_r.ptemp) |-> $past(ref_tmr.expired) || $past(latch_now))
		else $error("Primary temperature changed without a refresh.");

	// A cleared coil stops the heater on the next edge.
	chk_coil_gate: assert property (
		!st_r.heater_enable_coil |=> !heater_on_o && st_r.heat == S_WATCH)
		else $error("Heater active while the algorithm is disabled.");

	// Only our slave number is answered, one cycle later.
	chk_slave_answer: assert property (
		rsp_valid_o |-> $past(req_valid_i) && $past(req_slave_i) == SLAVE_NUM)
		else $error("Answer given to a foreign slave number.");

	// A good answer only follows function 04 or 05.
	chk_func_codes: assert property (
		(rsp_valid_o && !rsp_exc_o) |-> (rsp_func_o == FC_READ_INPUT) || (rsp_func_o == FC_WRITE_COIL))
		else $error("Good answer to an unsupported function.");

	// The status word reports the enable coil of the request cycle.
	chk_status_enable: assert property (
		(rsp_valid_o && rsp_func_o == FC_READ_INPUT && $past(req_addr_i) == REG_STATION_STATUS)
		|-> rsp_data_o[ST_ENABLE_BIT] == $past(st_r.heater_enable_coil))
		else $error("Status enable bit does not match the coil.");

	// Sequence timer is held at zero while disabled.
	chk_timer_reset: assert property (
		!st_r.heater_enable_coil |=> seq_tmr.count == 12'h000)
		else $error("Heater timer not cleared while disabled.");

	// Main scenarios.
	cov_heat_cycle: cover property ($fell(heater_on_o));
	cov_relatch: cover property (st_r.heat == S_COOL ##1 st_r.heat == S_LATCH);
	cov_read_status: cover property (rsp_valid_o && rsp_func_o == FC_READ_INPUT);
	cov_exception: cover property (rsp_valid_o && rsp_exc_o);
endmodule : wmr_regs_heater

// >>> wmr_master_model.sv
`timescale 1ns/10ps
// Far-side bus master: one request at a time, then collects the answer pulse.
module wmr_master_model (
	// Clock.
	input wire logic sys_clk_i,
	// Request lines.
	output logic req_valid_o,
	output logic [7:0] req_slave_o,
	output logic [7:0] req_func_o,
	output logic [15:0] req_addr_o,
	output logic [15:0] req_data_o,
	// Answer lines.
	input wire logic rsp_valid_i,
	input wire logic [7:0] rsp_func_i,
	input wire logic [15:0] rsp_data_i,
	input wire logic rsp_exc_i
);
	import wmr_pkg::*;

	// Lines start idle so nothing is requested before the bench asks.
	initial begin
		req_valid_o = 1'b0;
		{req_slave_o, req_func_o, req_addr_o, req_data_o} = '0;
	end

	// Raw request; fields are inverted after the taking edge so no stale value lingers.
	task automatic xfer(input logic [7:0] slv, input logic [7:0] fc, input logic [15:0] adr,
			input logic [15:0] dat, output logic got, output logic [7:0] rf,
			output logic [15:0] rd, output logic re);
		got = 1'b0;
		{rf, rd, re} = '0;
		@(posedge sys_clk_i);
		#2;
		req_valid_o = 1'b1;
		{req_slave_o, req_func_o, req_addr_o, req_data_o} = {slv, fc, adr, dat};
		@(posedge sys_clk_i);
		#2;
		req_valid_o = 1'b0;
		{req_slave_o, req_func_o, req_addr_o, req_data_o} = ~{slv, fc, adr, dat};
		// The answer pulse is awaited over a bounded number of edges.
		for (int i = 0; i < 3; i++) begin
			if (!got && rsp_valid_i === 1'b1) begin
				got = 1'b1;
				{rf, rd, re} = {rsp_func_i, rsp_data_i, rsp_exc_i};
			end
			@(posedge sys_clk_i);
			#2;
		end
	endtask : xfer

	// Reads an input register given by its register number.
	task automatic read_reg(input int regnum, output logic got, output logic [15:0] rd);
		logic [7:0] rf;
		logic re;
		xfer(SLAVE_NUM, FC_READ_INPUT, 16'(regnum - INPUT_REG_BASE), 16'h0000,
			got, rf, rd, re);
	endtask : read_reg

	// Sets or clears the heater enable coil.
	task automatic write_coil(input logic on, output logic got);
		logic [7:0] rf;
		logic [15:0] rd;
		logic re;
		xfer(SLAVE_NUM, FC_WRITE_COIL, COIL_HEATER_ENABLE,
			on ? COIL_VAL_ON : COIL_VAL_OFF, got, rf, rd, re);
	endtask : write_coil
endmodule : wmr_master_model

// >>> wmr_regs_heater_tb.sv
`timescale 1ns/10ps
// Self-checking bench for the register bank and the heater sequence.
module wmr_regs_heater_tb;
	import wmr_pkg::*;

	localparam int TCK = 4; // Clocks per simulated second, kept short.
	localparam logic [15:0] ID_VAL = 16'h1234; // Arbitrary identifier value.

	// One table row: request fields beside the answer they should give.
	typedef struct {
		logic [7:0] fc;
		logic [15:0] adr;
		logic [15:0] dat;
		logic [15:0] exp;
		logic exc;
	} wmr_row_type;

	logic sys_clk, reset, req_valid, rsp_valid, rsp_exc, heater_on;
	logic [7:0] req_slave, req_func, rsp_func;
	logic [15:0] req_addr, req_data, rsp_data, primary_temp;
	logic [15:0] m [0:10]; // Measurement inputs in port order.
	wmr_row_type rows [$];
	int mismatches, n_compared;

	// Clock of 25 ns.
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	wmr_regs_heater #(.TICK_CYCLES(TCK), .DEVICE_IDENTIFIER(ID_VAL)) i_dut (
		.sys_clk_i(sys_clk), .reset_i(reset),
		.req_valid_i(req_valid), .req_slave_i(req_slave), .req_func_i(req_func),
		.req_addr_i(req_addr), .req_data_i(req_data),
		.rsp_valid_o(rsp_valid), .rsp_func_o(rsp_func), .rsp_data_o(rsp_data),
		.rsp_exc_o(rsp_exc),
		.wind_direction_i(m[0]), .wind_speed_mean_i(m[1]), .wind_gust_peak_i(m[2]),
		.temp_sample_i(m[3]), .rain_last_hour_i(m[4]), .rain_last_day_i(m[5]),
		.relative_humidity_i(m[6]), .barometric_pressure_i(m[7]), .luminosity_i(m[8]),
		.rain_raw_count_i(m[9]), .backup_temperature_i(m[10]),
		.heater_on_o(heater_on), .primary_temperature_o(primary_temp));

	wmr_master_model i_master (
		.sys_clk_i(sys_clk), .req_valid_o(req_valid), .req_slave_o(req_slave),
		.req_func_o(req_func), .req_addr_o(req_addr), .req_data_o(req_data),
		.rsp_valid_i(rsp_valid), .rsp_func_i(rsp_func), .rsp_data_i(rsp_data),
		.rsp_exc_i(rsp_exc));

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	// Compares a sixteen-bit value.
	task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk16

	// Compares a single flag.
	task automatic chk1(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask : chk1

	// Compares a measured clock count against a window.
	task automatic chk_rng(input string nm, input int lo, input int hi, input int n);
		n_compared++;
		if (n < lo || n > hi) begin
			mismatches++;
			$display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, n);
		end
	endtask : chk_rng

	// Counts clocks until the heater reaches the level, giving up at the limit.
	task automatic wait_heat(input logic lvl, input int lim, output int n);
		n = 0;
		while (n < lim && heater_on !== lvl) begin
			@(posedge sys_clk);
			#2;
			n++;
		end
	endtask : wait_heat

	// Reads a register by number and compares it.
	task automatic rd_chk(input string nm, input int regnum, input logic [15:0] e);
		logic got;
		logic [15:0] d;
		i_master.read_reg(regnum, got, d);
		chk1("answered", 1'b1, got);
		chk16(nm, e, d);
	endtask : rd_chk

	// Value a read of an address should return with the coil clear.
	function automatic logic [15:0] exp_reg(input int a);
		if (a == 0) return ID_VAL;
		if (a == 7 || a == 11 || a == 14) return 16'h0000;
		if (a < 7) return m[a - 1];
		if (a < 11) return m[a - 2];
		return m[a - 3];
	endfunction : exp_reg

	// Watchdog sized above the roughly 39000 clocks the tests need.
	initial begin
		repeat (60000) @(posedge sys_clk);
		mismatches++;
		stop_test();
	end

	// Main sequence.
	initial begin
		int n;
		logic got, re;
		logic [7:0] rf;
		logic [15:0] rd;
		mismatches = 0;
		n_compared = 0;
		reset = 1'b1;
		m = '{16'h0D05, 16'h01F4, 16'h03E8, 16'hFF38, 16'h0064, 16'h0190, 16'h1F40,
			16'h27B5, 16'h0050, 16'h0320, 16'hFF42};
		repeat (3) @(posedge sys_clk);
		#2;
		reset = 1'b0;
		chk16("temp after reset", 16'h0000, primary_temp);
		chk1("heater after reset", 1'b0, heater_on);
		wait_heat(1'b1, 4 * TCK, n);
		// Reads of every address, then the refused requests and a good coil clear.
		for (int a = 0; a < 15; a++) begin
			rows.push_back('{FC_READ_INPUT, 16'(a), 16'h0000, exp_reg(a), 1'b0});
		end
		rows.push_back('{8'h03, 16'h0000, 16'h0000, 16'h0001, 1'b1});
		rows.push_back('{FC_READ_INPUT, 16'h000F, 16'h0000, 16'h0002, 1'b1});
		rows.push_back('{FC_WRITE_COIL, 16'h0001, COIL_VAL_ON, 16'h0002, 1'b1});
		rows.push_back('{FC_WRITE_COIL, 16'h0000, 16'h1234, 16'h0003, 1'b1});
		rows.push_back('{FC_WRITE_COIL, 16'h0000, COIL_VAL_OFF, COIL_VAL_OFF, 1'b0});
		foreach (rows[i]) begin
			i_master.xfer(SLAVE_NUM, rows[i].fc, rows[i].adr, rows[i].dat, got, rf, rd, re);
			chk1("answered", 1'b1, got);
			chk16("func", {8'h00, rows[i].fc | (rows[i].exc ? EXC_FLAG : 8'h00)}, {8'h00, rf});
			chk1("exception", rows[i].exc, re);
			chk16("data", rows[i].exp, rd);
		end
		rd_chk("status after bad coil value", 30015, 16'h0000);
		i_master.xfer(8'h0D, FC_READ_INPUT, 16'h0000, 16'h0000, got, rf, rd, re);
		chk1("other slave ignored", 1'b0, got);
		$display("Test register table done");
		// First humid hour, heating and cool-down with a relatch.
		m[6] = 16'h251D;
		i_master.write_coil(1'b1, got);
		rd_chk("status enabled", 30015, 16'h0004);
		wait_heat(1'b1, 3700 * TCK, n);
		chk_rng("humid hour", 3595 * TCK, 3603 * TCK, n);
		chk16("latched temp", 16'hFF38, primary_temp);
		rd_chk("status heating", 30015, 16'h0007);
		m[3] = 16'h0A28;
		wait_heat(1'b0, 700 * TCK, n);
		chk_rng("heat time", 598 * TCK, 601 * TCK, n);
		chk16("held temp", 16'hFF38, primary_temp);
		rd_chk("status cooling", 30015, 16'h0006);
		m[3] = 16'h0190;
		wait_heat(1'b1, 700 * TCK, n);
		chk_rng("cool time", 596 * TCK, 602 * TCK, n);
		chk16("relatched temp", 16'h0190, primary_temp);
		$display("Test heating cycle done");
		// Humidity at exactly the limit ends the sequence.
		m[6] = HUM_LIMIT;
		wait_heat(1'b0, 700 * TCK, n);
		chk_rng("second heat", 599 * TCK, 601 * TCK, n);
		wait_heat(1'b1, 620 * TCK, n);
		chk_rng("no reheat", 620 * TCK, 620 * TCK, n);
		rd_chk("status watching", 30015, 16'h0004);
		m[3] = 16'h0123;
		wait_heat(1'b1, 4 * TCK, n);
		chk16("fast refresh", 16'h0123, primary_temp);
		m[6] = 16'h251D;
		wait_heat(1'b1, 3700 * TCK, n);
		chk_rng("new humid hour", 3599 * TCK, 3603 * TCK, n);
		$display("Test dry restart done");
		// Disable mid-heat, re-enable, then reset in mid-run.
		i_master.write_coil(1'b0, got);
		chk1("heater disabled", 1'b0, heater_on);
		rd_chk("status disabled", 30015, 16'h0000);
		i_master.write_coil(1'b1, got);
		wait_heat(1'b1, 100 * TCK, n);
		chk_rng("timers cleared", 100 * TCK, 100 * TCK, n);
		reset = 1'b1;
		repeat (3) @(posedge sys_clk);
		#2;
		reset = 1'b0;
		rd_chk("status after reset", 30015, 16'h0000);
		$display("Test disable and reset done");
		stop_test();
	end
endmodule : wmr_regs_heater_tb
